// ### bench/test_lvdc_core.sv
`timescale 1ns/1ps
// one comparison: count it, report a mismatch at once
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_lvdc_core
    import lvdc_pkg::*;
;
    // stimulus and observed ports
    logic       i_clk;
    logic       i_rst_n;
    logic       i_other_rst_n;
    logic       i_below_async;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    wire  [7:0] o_rdata;
    wire  [3:0] o_level_code;
    wire        o_source_select;
    wire        o_detector_on;
    wire        o_internal_reset;
    wire        o_detect_irq;
    wire        o_event_irq;
    int         errors = 0;
    int         n_checks = 0;
    logic [15:0] notes[$];   // {care mask, expected byte}
    string      names[$];
    logic [15:0] nt;
    string      nm;
    logic       rd_q = 1'b0;
    logic [3:0] lv;

    lvdc_core i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_other_rst_n(i_other_rst_n),
        .i_below_async(i_below_async), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_level_code(o_level_code),
        .o_source_select(o_source_select), .o_detector_on(o_detector_on),
        .o_internal_reset(o_internal_reset), .o_detect_irq(o_detect_irq),
        .o_event_irq(o_event_irq));

    ////////////////////////////////////////////////////////////////////////////////
    // 20 mhz clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge i_clk) begin
        if (rd_q && notes.size() > 0) begin
            nt = notes.pop_front();
            nm = names.pop_front();
            `CHK(nm, nt[7:0], o_rdata & nt[15:8])
        end
        rd_q <= i_rd;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles: one strobe cycle each, expectation noted when the read is issued
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
                      input string s);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        notes.push_back({m, e});
        names.push_back(s);
        @(posedge i_clk);
        i_rd   <= 1'b0;
    endtask

    // wait, then step past the edge so pin samples are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: 3000 cycles, about four times the test with its three stabilization waits
    initial begin
        repeat (3000) @(posedge i_clk);
        errors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        i_rst_n = 1'b0; i_other_rst_n = 1'b1; i_below_async = 1'b0;
        i_addr = 4'h0; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
        void'($urandom(16));
        lv = 4'($urandom());
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(LVDC_ADDR_CTRL, LVDC_CTRL_RST, 8'hff, "ctrl_rst");
        rd(LVDC_ADDR_IRQ, 8'h02, 8'hff, "irq_rst");
        wr(LVDC_ADDR_LEVEL, {4'h0, lv});
        rd(LVDC_ADDR_LEVEL, {4'h0, lv}, 8'h0f, "level");
        rd(4'h3, 8'h00, 8'hff, "unmapped");
        // interrupt mode on the supply: both crossings raise the request
        wr(LVDC_ADDR_CTRL, 8'h80);
        cyc(LVDC_STAB_CYC);
        `CHK("level_out", lv, o_level_code)
        `CHK("on_out", 1'b1, o_detector_on)
        rd(LVDC_ADDR_CTRL, 8'h80, 8'hff, "ctrl_good");
        wr(LVDC_ADDR_IRQ, 8'h00);
        wr(LVDC_ADDR_MASK, 8'h03);
        i_below_async <= 1'b1;
        cyc(5);
        `CHK("irq_fall", 1'b1, o_detect_irq)
        `CHK("event_fall", 1'b1, o_event_irq)
        rd(LVDC_ADDR_CTRL, 8'h81, 8'hff, "ctrl_low");
        rd(LVDC_ADDR_STAT, 8'h01, 8'h03, "stat_fall");
        wr(LVDC_ADDR_STAT, 8'h07);
        wr(LVDC_ADDR_IRQ, 8'h00);
        cyc(2);
        `CHK("irq_clr", 1'b0, o_detect_irq)
        `CHK("event_clr", 1'b0, o_event_irq)
        @(posedge i_clk);
        i_below_async <= 1'b0;
        cyc(5);
        `CHK("irq_rise", 1'b1, o_detect_irq)
        rd(LVDC_ADDR_STAT, 8'h02, 8'h03, "stat_rise");
        // switching off while low must still raise the request
        i_below_async <= 1'b1;
        cyc(5);
        wr(LVDC_ADDR_IRQ, 8'h00);
        wr(LVDC_ADDR_CTRL, 8'h00);
        cyc(3);
        rd(LVDC_ADDR_IRQ, 8'h01, 8'h03, "irq_off_low");
        // reset mode on the pin: no reset while good, reset while low
        wr(LVDC_ADDR_IRQ, 8'h02);
        i_below_async <= 1'b0;
        wr(LVDC_ADDR_CTRL, 8'h84);
        cyc(LVDC_STAB_CYC);
        `CHK("sel_out", 1'b1, o_source_select)
        rd(LVDC_ADDR_CTRL, 8'h84, 8'hff, "pin_good");
        wr(LVDC_ADDR_CTRL, 8'h86);
        repeat (8) begin
            cyc(1);
            `CHK("no_reset", 1'b0, o_internal_reset)
        end
        @(posedge i_clk);
        i_below_async <= 1'b1;
        cyc(5);
        `CHK("reset_low", 1'b1, o_internal_reset)
        rd(LVDC_ADDR_CTRL, 8'h87, 8'hff, "ctrl_kept");
        rd(LVDC_ADDR_IRQ, 8'h02, 8'h02, "mask_set");
        rd(LVDC_ADDR_CAUSE, 8'h01, 8'h01, "cause_set");
        rd(LVDC_ADDR_STAT, 8'h04, 8'h04, "stat_rst");
        i_below_async <= 1'b0;
        cyc(6);
        `CHK("reset_gone", 1'b0, o_internal_reset)
        wr(LVDC_ADDR_CAUSE, 8'h01);
        rd(LVDC_ADDR_CAUSE, 8'h00, 8'h01, "cause_clr");
        wr(LVDC_ADDR_CTRL, 8'h84);
        wr(LVDC_ADDR_CTRL, 8'h04);
        rd(LVDC_ADDR_CTRL, 8'h04, 8'hff, "ctrl_stop");
        // reset mode on the supply: no reset while good, then switched off
        wr(LVDC_ADDR_CTRL, 8'h80);
        cyc(LVDC_STAB_CYC);
        `CHK("sel_supply", 1'b0, o_source_select)
        rd(LVDC_ADDR_CTRL, 8'h80, 8'hff, "supply_good");
        wr(LVDC_ADDR_CTRL, 8'h82);
        cyc(3);
        `CHK("supply_no_reset", 1'b0, o_internal_reset)
        wr(LVDC_ADDR_CTRL, 8'h00);
        rd(LVDC_ADDR_CTRL, 8'h00, 8'hff, "supply_stop");
        // a reset from elsewhere clears the control byte and level code
        wr(LVDC_ADDR_CTRL, 8'h80);
        wr(LVDC_ADDR_IRQ, 8'h00);
        i_other_rst_n <= 1'b0;
        @(posedge i_clk);
        i_other_rst_n <= 1'b1;
        rd(LVDC_ADDR_CTRL, 8'h00, 8'hff, "ctrl_other");
        rd(LVDC_ADDR_LEVEL, 8'h00, 8'h0f, "level_other");
        rd(LVDC_ADDR_IRQ, 8'h02, 8'h02, "mask_other");
        cyc(4);
        `CHK("on_other", 1'b0, o_detector_on)
        `CHK("level_out_other", 4'h0, o_level_code)
        `CHK("notes_left", 0, notes.size())
        wrap_up();
    end
endmodule

// ### hdl/lvdc_core.sv
`timescale 1ns/1ps
// Overview of operation
// - setting reset mode while voltage is good raises no reset
// - every reset, detector reset included, sets the irq mask
// - clearing enable while voltage is low in irq mode raises the irq request
// - a detector reset is recorded in reset cause bit 0
// - crossings set no fall/rise flag and no request while in reset mode
// - reset mode holds reset while low, releases when good
// - irq mode raises irq on both falling and rising crossings
// - read-only flag bit 0 shows synchronised comparator state while enabled, zero when off
// - other resets clear control byte; detector reset keeps it
module lvdc_core
    import lvdc_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // chip reset other than ours, active low, synchronous
    input  wire logic       i_other_rst_n,
    // analog comparator: high while monitored voltage is below threshold
    input  wire logic       i_below_async,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // to analog and system
    output logic      [3:0] o_level_code,
    output logic            o_source_select,
    output logic            o_detector_on,
    output logic            o_internal_reset,
    output logic            o_detect_irq,
    output logic            o_event_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser; first stage feeds only the second
    logic sync1_r, sync2_r, below_r;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            below_r <= 1'b0;
        end else begin
            sync1_r <= i_below_async;
            sync2_r <= sync1_r;
            below_r <= sync2_r;        // previous value for edges
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state
    lvdc_ctrl_type ctrl_r, ctrl_nxt;
    logic [3:0] level_r, level_nxt;
    logic       req_r, req_nxt;
    logic       msk_r, msk_nxt;
    logic       cause_r, cause_nxt;
    logic [2:0] stat_r, stat_nxt;
    logic [2:0] emask_r, emask_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       lvrst_r, lvrst_nxt;

    logic below, fall_ev, rise_ev, off_low, wr_ctrl;
    logic [7:0] ctrl_byte;

    assign below   = ctrl_r.on & sync2_r;  // flag reads zero while disabled
    assign fall_ev = ctrl_r.on & ~ctrl_r.mode & sync2_r & ~below_r;
    assign rise_ev = ctrl_r.on & ~ctrl_r.mode & ~sync2_r & below_r;
    assign wr_ctrl = i_wr && (i_addr == LVDC_ADDR_CTRL);
    // turning off while low in irq mode gives a request
    assign off_low = wr_ctrl & ctrl_r.on & ~ctrl_r.mode & sync2_r
                     & ~i_wdata[LVDC_BIT_ON];

    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[LVDC_BIT_ON]   = ctrl_r.on;
        ctrl_byte[LVDC_BIT_SEL]  = ctrl_r.sel;
        ctrl_byte[LVDC_BIT_MODE] = ctrl_r.mode;
        ctrl_byte[LVDC_BIT_FLAG] = below;
    end

    // next-state for all registers
    always_comb begin
        ctrl_nxt  = ctrl_r;
        level_nxt = level_r;
        req_nxt   = req_r;
        msk_nxt   = msk_r;
        cause_nxt = cause_r;
        emask_nxt = emask_r;
        stat_nxt  = stat_r;
        rdata_nxt = 8'h00;
        // reset request only while enabled, reset mode and low; none if good
        lvrst_nxt = ctrl_r.on & ctrl_r.mode & sync2_r;
        if (wr_ctrl) begin
            ctrl_nxt.on   = i_wdata[LVDC_BIT_ON];
            ctrl_nxt.sel  = i_wdata[LVDC_BIT_SEL];
            ctrl_nxt.mode = i_wdata[LVDC_BIT_MODE];
        end
        if (i_wr && i_addr == LVDC_ADDR_LEVEL) begin
            level_nxt = i_wdata[3:0];
        end
        if (i_wr && i_addr == LVDC_ADDR_IRQ) begin
            req_nxt = i_wdata[LVDC_BIT_REQ];
            msk_nxt = i_wdata[LVDC_BIT_MSK];
        end
        if (i_wr && i_addr == LVDC_ADDR_CAUSE) begin
            cause_nxt = cause_r & ~i_wdata[LVDC_BIT_CAUSE];
        end
        if (i_wr && i_addr == LVDC_ADDR_MASK) begin
            emask_nxt = i_wdata[2:0];
        end
        if (i_wr && i_addr == LVDC_ADDR_STAT) begin
            stat_nxt = stat_r & ~i_wdata[2:0];
        end
        // hardware sets win over software clears
        if (fall_ev || rise_ev || off_low) begin
            req_nxt = 1'b1;
        end
        stat_nxt[LVDC_EV_FALL] = stat_nxt[LVDC_EV_FALL] | fall_ev | off_low;
        stat_nxt[LVDC_EV_RISE] = stat_nxt[LVDC_EV_RISE] | rise_ev;
        stat_nxt[LVDC_EV_RST]  = stat_nxt[LVDC_EV_RST] | (lvrst_nxt & ~lvrst_r);
        // our own reset: mask set, cause recorded, control kept
        if (lvrst_r) begin
            msk_nxt   = 1'b1;
            cause_nxt = 1'b1;
        end
        if (i_rd) begin
            unique case (i_addr)
                LVDC_ADDR_CTRL:  rdata_nxt = ctrl_byte;
                LVDC_ADDR_LEVEL: rdata_nxt = {4'h0, level_r};
                LVDC_ADDR_IRQ:   rdata_nxt = {6'h00, msk_r, req_r};
                LVDC_ADDR_CAUSE: rdata_nxt = {7'h00, cause_r};
                LVDC_ADDR_STAT:  rdata_nxt = {5'h00, stat_r};
                LVDC_ADDR_MASK:  rdata_nxt = {5'h00, emask_r};
                default:         rdata_nxt = 8'h00;  // unmapped reads zero
            endcase
        end
    end

    // registers; the other chip resets clear everything, mask goes to one
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_other_rst_n) begin
            ctrl_r  <= '0;
            level_r <= LVDC_LEVEL_RST;
            req_r   <= 1'b0;
            msk_r   <= 1'b1;
            cause_r <= 1'b0;
            stat_r  <= LVDC_STAT_RST;
            emask_r <= LVDC_MASK_RST;
            rdata_r <= 8'h00;
            lvrst_r <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            level_r <= level_nxt;
            req_r   <= req_nxt;
            msk_r   <= msk_nxt;
            cause_r <= cause_nxt;
            stat_r  <= stat_nxt;
            emask_r <= emask_nxt;
            rdata_r <= rdata_nxt;
            lvrst_r <= lvrst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rdata          = rdata_r;
    assign o_level_code     = level_r;
    assign o_source_select  = ctrl_r.sel;
    assign o_detector_on    = ctrl_r.on;
    assign o_internal_reset = lvrst_r;
    assign o_detect_irq     = req_r & ~msk_r;        // mask gates delivery
    assign o_event_irq      = |(stat_r & emask_r);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    reset_when_low_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        (ctrl_r.on && ctrl_r.mode && sync2_r) |=> o_internal_reset)
        else $error("reset not raised while low in reset mode");
    no_reset_good_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        !sync2_r |=> !o_internal_reset)
        else $error("reset raised while voltage good");
    mask_on_reset_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        o_internal_reset |=> msk_r)
        else $error("mask not set by detector reset");
    cause_record_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        o_internal_reset |=> cause_r)
        else $error("reset cause not recorded");
    ctrl_kept_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        (o_internal_reset && !i_wr) |=> $stable(ctrl_r))
        else $error("control changed by detector reset");
    edge_req_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        (fall_ev || rise_ev) |=> req_r)
        else $error("crossing did not set request");
    off_low_req_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        off_low |=> (req_r && !ctrl_r.on))
        else $error("off while low gave no request");
    // flag is traced back to the pin itself: three stages from pin to read data
    flag_follow_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        (i_rd && i_addr == LVDC_ADDR_CTRL)
        |=> (o_rdata[LVDC_BIT_FLAG] == ($past(ctrl_r.on) && $past(i_below_async, 3))))
        else $error("flag read does not match comparator");
    sync_two_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_other_rst_n)
        ##2 (sync2_r == $past(i_below_async, 2)))
        else $error("comparator not passed through two stages");

endmodule

// ### pkg/lvdc_pkg.sv
package lvdc_pkg;

    // register map (byte addresses on the plain register port)
    localparam logic [3:0] LVDC_ADDR_CTRL   = 4'h0;  // detect_control_byte
    localparam logic [3:0] LVDC_ADDR_LEVEL  = 4'h4;  // level_select_byte
    localparam logic [3:0] LVDC_ADDR_IRQ    = 4'h8;  // detect_irq_request, detect_irq_mask
    localparam logic [3:0] LVDC_ADDR_CAUSE  = 4'hC;  // reset_cause_reg
    localparam logic [3:0] LVDC_ADDR_STAT   = 4'h1;  // sticky event status, w1c
    localparam logic [3:0] LVDC_ADDR_MASK   = 4'h2;  // event mask

    // control byte fields
    localparam int LVDC_BIT_ON   = 7;
    localparam int LVDC_BIT_SEL  = 2;
    localparam int LVDC_BIT_MODE = 1;
    localparam int LVDC_BIT_FLAG = 0;
    // irq register fields
    localparam int LVDC_BIT_REQ  = 0;
    localparam int LVDC_BIT_MSK  = 1;
    // reset cause field
    localparam int LVDC_BIT_CAUSE = 0;
    // status / mask fields
    localparam int LVDC_EV_FALL  = 0;
    localparam int LVDC_EV_RISE  = 1;
    localparam int LVDC_EV_RST   = 2;

    // reset values
    localparam logic [7:0] LVDC_CTRL_RST  = 8'h00;
    localparam logic [3:0] LVDC_LEVEL_RST = 4'h0;
    localparam logic [2:0] LVDC_STAT_RST  = 3'h0;
    localparam logic [2:0] LVDC_MASK_RST  = 3'h0;

    // timing: comparator stabilization, software waits this long
    localparam int LVDC_CLK_HZ      = 20_000_000;
    localparam int LVDC_STAB_US     = 10;
    localparam int LVDC_STAB_CYC    = (LVDC_STAB_US * LVDC_CLK_HZ) / 1_000_000;

    // control fields carried together
    typedef struct packed {
        logic on;
        logic sel;
        logic mode;
    } lvdc_ctrl_type;

endpackage
